// *** inc/qdc_defs.svh ***
// constants for the quad converter load and clear control
// assumes inclusion by the package and design files, bare name only
`ifndef QDC_DEFS_SVH
`define QDC_DEFS_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define QDC_WORD_W 16
`define QDC_CODE_W 12
`define QDC_CH_W 2
`define QDC_CH_MSB 15
`define QDC_CH_LSB 14
`define QDC_CODE_MSB 11
`define QDC_CODE_LSB 0
`define QDC_NUM_CH 4

// ----------------------------------------------------------------
// channel codes and clear levels
// ----------------------------------------------------------------
`define QDC_CH_A 2'h0
`define QDC_CH_B 2'h1
`define QDC_CH_C 2'h2
`define QDC_CH_D 2'h3
`define QDC_CLR_ZERO 12'h000
`define QDC_CLR_MID 12'h800

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define QDC_SYNC_W 3
`define QDC_SYNC_IDLE 3'h7
`define QDC_SYNC_LOW 3'h0
`define QDC_WORD_RST 16'h0000

`endif

// *** inc/qdc_pkg.sv ***
// types shared by the quad converter load and clear control
// assumes qdc_defs.svh on the include path
`include "qdc_defs.svh"

package qdc_pkg;

	// ----------------------------------------------------------------
	// channel field decode
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		QDC_CH_A = 2'b00,
		QDC_CH_B = 2'b01,
		QDC_CH_C = 2'b10,
		QDC_CH_D = 2'b11
	} qdc_chan_e;

	typedef logic [`QDC_CODE_W-1:0] qdc_code_t;

	// ----------------------------------------------------------------
	// state of the control in the system clock domain
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`QDC_SYNC_W-1:0] ld_sync;
		logic [`QDC_SYNC_W-1:0] clr_sync;
		logic [`QDC_SYNC_W-1:0] cs_sync;
		logic [`QDC_SYNC_W-1:0] sel_sync;
		logic ld_lvl;
		logic clr_lvl;
		logic cs_lvl;
		logic sel_lvl;
		logic [`QDC_WORD_W-1:0] input_word;
		logic [`QDC_NUM_CH-1:0][`QDC_CODE_W-1:0] dac;
	} qdc_ctl_s;

	// state of the serial shifter in the link domain
	typedef struct packed {
		logic [`QDC_WORD_W-1:0] shift;
	} qdc_link_s;

endpackage

// *** hw/qdc_shift.sv ***
// serial input shift register, runs on the serial clock
// assumes chip select is framed to the serial clock by the host
`include "qdc_defs.svh"

module qdc_shift
	import qdc_pkg::*;
#(
	parameter int WIDTH = `QDC_WORD_W
) (
	input wire logic serial_clk,
	input wire logic cs_n,
	input wire logic serial_data_in,
	output logic [WIDTH-1:0] shift_word
);

	// ----------------------------------------------------------------
	// shifter state
	// ----------------------------------------------------------------
	qdc_link_s r_reg, r_next;

	// msb first: each bit enters at the bottom and moves upward
	always_comb begin
		r_next = r_reg;
		if (!cs_n) begin
			r_next.shift = {r_reg.shift[`QDC_WORD_W-2:0], serial_data_in};
		end
	end

	// no reset here: the word only matters after a whole frame
	always_ff @(posedge serial_clk) begin
		r_reg <= r_next;
	end

	assign shift_word = r_reg.shift[WIDTH-1:0];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// no reset here, so only bits shifted in during the run are compared
	chk_shift_msb_first: assert property (@(posedge serial_clk)
		!cs_n ##1 !cs_n |=> shift_word[1:0] == {$past(serial_data_in, 2), $past(serial_data_in)})
		else $error("serial bit not shifted in msb first");

	chk_shift_hold_idle: assert property (@(posedge serial_clk)
		cs_n |=> $stable(shift_word))
		else $error("shifter moved with chip select high");

endmodule // qdc_shift

// *** hw/qdc_top.sv ***
// load and clear control for a four channel 12-bit converter
// assumes async pins from the host, serial clock as its own domain
`include "qdc_defs.svh"

module qdc_top
	import qdc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clk,
	input wire logic cs_n,
	input wire logic serial_data_in,
	input wire logic load_strobe_n,
	input wire logic clear_n,
	input wire logic clear_level_select,
	output logic [`QDC_CODE_W-1:0] dac_a_code,
	output logic [`QDC_CODE_W-1:0] dac_b_code,
	output logic [`QDC_CODE_W-1:0] dac_c_code,
	output logic [`QDC_CODE_W-1:0] dac_d_code,
	output logic [`QDC_WORD_W-1:0] input_word
);

	// ----------------------------------------------------------------
	// link domain: serial shifter
	// ----------------------------------------------------------------
	logic [`QDC_WORD_W-1:0] link_word;

	// no reset in the link domain: serial_clk may stand still while rstn is low
	// the host frames cs to the serial clock, so no sync in this domain
	qdc_shift #(
		.WIDTH(`QDC_WORD_W)
	) u_shift (
		.serial_clk(serial_clk),
		.cs_n(cs_n),
		.serial_data_in(serial_data_in),
		.shift_word(link_word)
	);

	// ----------------------------------------------------------------
	// system domain state
	// ----------------------------------------------------------------
	// one packed state word, registered as a whole below
	qdc_ctl_s r_reg, r_next;

	logic load_evt;
	logic cap_evt;
	logic clr_act;
	qdc_chan_e chan;
	qdc_code_t clr_code;

	// filtered levels: a change counts once flops two and three agree
	// a disagreement keeps the old level, so a one-clock glitch never counts
	function automatic logic settle(input logic [`QDC_SYNC_W-1:0] s, input logic lvl);
		settle = (s[1] == s[2]) ? s[2] : lvl;
	endfunction

	// event decode from the filtered levels
	always_comb begin
		load_evt = r_reg.ld_lvl && !settle(r_reg.ld_sync, r_reg.ld_lvl);
		// the shifter is frozen while cs is high, so its word is quasi-static here
		cap_evt = !r_reg.cs_lvl && settle(r_reg.cs_sync, r_reg.cs_lvl);
		// same settle point as the strobe, so a clear and a load falling together coincide
		clr_act = !settle(r_reg.clr_sync, r_reg.clr_lvl);
		chan = qdc_chan_e'(r_reg.input_word[`QDC_CH_MSB:`QDC_CH_LSB]);
		clr_code = r_reg.sel_lvl ? `QDC_CLR_MID : `QDC_CLR_ZERO;
	end

	// next state: synchronisers, input register, converter registers
	always_comb begin
		r_next = r_reg;
		// first flop is only read by the second
		r_next.ld_sync = {r_reg.ld_sync[1:0], load_strobe_n};
		r_next.clr_sync = {r_reg.clr_sync[1:0], clear_n};
		r_next.cs_sync = {r_reg.cs_sync[1:0], cs_n};
		r_next.sel_sync = {r_reg.sel_sync[1:0], clear_level_select};
		r_next.ld_lvl = settle(r_reg.ld_sync, r_reg.ld_lvl);
		r_next.clr_lvl = settle(r_reg.clr_sync, r_reg.clr_lvl);
		r_next.cs_lvl = settle(r_reg.cs_sync, r_reg.cs_lvl);
		r_next.sel_lvl = settle(r_reg.sel_sync, r_reg.sel_lvl);
		// clear never touches the input register
		if (cap_evt) begin
			r_next.input_word = link_word;
		end
		if (clr_act) begin
			// clear wins over any load strobe in the same cycle
			for (int i = 0; i < `QDC_NUM_CH; i++) begin
				r_next.dac[i] = clr_code;
			end
		end else if (load_evt) begin
			// relies on the host not shifting while the strobe is low
			// only the addressed register moves; the other three keep their codes
			unique case (chan)
				QDC_CH_A: r_next.dac[`QDC_CH_A] = r_reg.input_word[`QDC_CODE_MSB:`QDC_CODE_LSB];
				QDC_CH_B: r_next.dac[`QDC_CH_B] = r_reg.input_word[`QDC_CODE_MSB:`QDC_CODE_LSB];
				QDC_CH_C: r_next.dac[`QDC_CH_C] = r_reg.input_word[`QDC_CODE_MSB:`QDC_CODE_LSB];
				QDC_CH_D: r_next.dac[`QDC_CH_D] = r_reg.input_word[`QDC_CODE_MSB:`QDC_CODE_LSB];
			endcase
		end
		// otherwise the registers hold, cleared value included
	end

	// synchronous active-low reset to idle pin levels and zero codes
	always_ff @(posedge clk) begin
		if (!rstn) begin
			// sync chains start at the idle pin level, so release makes no false edge
			r_reg.ld_sync <= `QDC_SYNC_IDLE;
			r_reg.clr_sync <= `QDC_SYNC_IDLE;
			r_reg.cs_sync <= `QDC_SYNC_IDLE;
			r_reg.sel_sync <= `QDC_SYNC_LOW;
			r_reg.ld_lvl <= 1'b1;
			r_reg.clr_lvl <= 1'b1;
			r_reg.cs_lvl <= 1'b1;
			r_reg.sel_lvl <= 1'b0;
			r_reg.input_word <= `QDC_WORD_RST;
			for (int i = 0; i < `QDC_NUM_CH; i++) begin
				r_reg.dac[i] <= `QDC_CLR_ZERO;
			end
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, straight from flops
	// ----------------------------------------------------------------
	// r_reg is the only source, so every output is a flop output
	assign dac_a_code = r_reg.dac[`QDC_CH_A];
	assign dac_b_code = r_reg.dac[`QDC_CH_B];
	assign dac_c_code = r_reg.dac[`QDC_CH_C];
	assign dac_d_code = r_reg.dac[`QDC_CH_D];
	assign input_word = r_reg.input_word;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// one sequence per channel, so a misrouted load is named by the check that fires
	sequence s_load_a;
		load_evt && !clr_act && chan == QDC_CH_A;
	endsequence

	sequence s_load_d;
		load_evt && !clr_act && chan == QDC_CH_D;
	endsequence

	sequence s_load_b;
		load_evt && !clr_act && chan == QDC_CH_B;
	endsequence

	sequence s_load_c;
		load_evt && !clr_act && chan == QDC_CH_C;
	endsequence

	sequence s_clear_seen;
		$fell(clear_n) ##1 !clear_n [*4];
	endsequence

	chk_load_chan_a: assert property (s_load_a |=>
		dac_a_code == $past(input_word[`QDC_CODE_MSB:`QDC_CODE_LSB]) && $stable(dac_b_code))
		else $error("load to channel a did not copy the input data");

	chk_load_chan_d: assert property (s_load_d |=>
		dac_d_code == $past(input_word[`QDC_CODE_MSB:`QDC_CODE_LSB]) && $stable(dac_a_code))
		else $error("load to channel d went to the wrong register");

	chk_load_chan_b: assert property (s_load_b |=>
		dac_b_code == $past(input_word[`QDC_CODE_MSB:`QDC_CODE_LSB]) && $stable(dac_c_code))
		else $error("load to channel b went to the wrong register");

	chk_load_chan_c: assert property (s_load_c |=>
		dac_c_code == $past(input_word[`QDC_CODE_MSB:`QDC_CODE_LSB]) && $stable(dac_d_code))
		else $error("load to channel c went to the wrong register");

	chk_clear_zero_all: assert property (clr_act && !r_reg.sel_lvl |=>
		dac_a_code == `QDC_CLR_ZERO && dac_b_code == `QDC_CLR_ZERO &&
		dac_c_code == `QDC_CLR_ZERO && dac_d_code == `QDC_CLR_ZERO)
		else $error("clear with select low did not give zero scale");

	chk_clear_mid_all: assert property (clr_act && r_reg.sel_lvl |=>
		dac_a_code == `QDC_CLR_MID && dac_b_code == `QDC_CLR_MID &&
		dac_c_code == `QDC_CLR_MID && dac_d_code == `QDC_CLR_MID)
		else $error("clear with select high did not give midscale");

	chk_clear_over_load: assert property (clr_act && load_evt |=>
		dac_a_code == $past(clr_code) && dac_c_code == $past(clr_code))
		else $error("load strobe overrode an active clear");

	chk_clear_hold_val: assert property (!clr_act && !load_evt |=>
		$stable(dac_a_code) && $stable(dac_b_code) && $stable(dac_c_code) && $stable(dac_d_code))
		else $error("converter register moved without load or clear");

	chk_input_kept: assert property (clr_act && !cap_evt |=> $stable(input_word))
		else $error("clear disturbed the input register");

	// counted from the pin: three sync flops, then the settle point
	chk_clear_async: assert property (s_clear_seen |-> clr_act)
		else $error("clear not acted on within four cycles");

	chk_capture_word: assert property (cap_evt |=> input_word == $past(link_word))
		else $error("input register missed the shifted word");

	chk_input_only_capture: assert property (!cap_evt |=> $stable(input_word))
		else $error("input register moved without a capture");

	chk_load_single_shot: assert property (load_evt |=> !load_evt)
		else $error("one strobe produced more than one load");

endmodule // qdc_top

// *** testbench/qdc_host_model.sv ***
// host side model: drives the serial link of the converter control
// assumes the bench calls send_word only with the load strobe high
module qdc_host_model (
	output logic serial_clk,
	output logic cs_n,
	output logic serial_data_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// link idle: clock parked high, no frame open
	// ------------------------------------------------------------
	initial begin
		serial_clk = 1'b1;
		cs_n = 1'b1;
		serial_data_in = 1'b0;
	end

	// one 16-bit frame at a 15 ns link period, msb first
	task automatic send_word(input logic [15:0] word);
		#3.3; // no phase tie to the system clock
		cs_n = 1'b0; // clock already high, so the shifter sees no edge
		#7.5;
		for (int i = 15; i >= 0; i--) begin // channel bits, two spare, data msb first
			serial_clk = 1'b0;
			serial_data_in = word[i];
			#7.5;
			serial_clk = 1'b1;
			#7.5;
		end
		cs_n = 1'b1; // raised while the clock stands high
		serial_data_in = ~word[0]; // released line never shows the stale bit
	endtask
endmodule // qdc_host_model

// *** testbench/qdc_top_tb.sv ***
// self-checking bench for the load and clear control
// assumes qdc_defs.svh on the include path and the host model beside it
`include "qdc_defs.svh"

module qdc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import qdc_pkg::*;

	logic clk, rstn, serial_clk, cs_n, serial_data_in;
	logic load_strobe_n, clear_n, clear_level_select;
	logic [11:0] dac_a_code, dac_b_code, dac_c_code, dac_d_code;
	logic [15:0] input_word;
	logic [11:0] cur [4];
	logic [15:0] last_word;
	int fail_count = 0;
	int comparisons = 0;
	// boundary and pattern data values, one per channel
	localparam logic [11:0] DATA [4] = '{12'hfff, 12'h001, 12'h7ff, 12'ha5c};

	// ------------------------------------------------------------
	// clock, design and host
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	qdc_top uut (.clk(clk), .rstn(rstn), .serial_clk(serial_clk), .cs_n(cs_n),
		.serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
		.clear_level_select(clear_level_select), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
		.dac_c_code(dac_c_code), .dac_d_code(dac_d_code), .input_word(input_word));
	qdc_host_model host (.serial_clk(serial_clk), .cs_n(cs_n), .serial_data_in(serial_data_in));

	// ------------------------------------------------------------
	// compare and access tasks
	// ------------------------------------------------------------
	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// all four codes against the expected table
	task automatic check_codes();
		logic [11:0] seen [4];
		seen[0] = dac_a_code;
		seen[1] = dac_b_code;
		seen[2] = dac_c_code;
		seen[3] = dac_d_code;
		for (int i = 0; i < 4; i++) begin
			comparisons++;
			if (seen[i] !== cur[i]) begin
				fail_count++;
				$display("[ERR] dac code %0d expected %h seen %h", i, cur[i], seen[i]);
			end
		end
	endtask

	// shift a word, then allow the synchronised capture
	task automatic send(input logic [1:0] ch, input logic [11:0] data);
		last_word = {ch, 2'b01, data};
		host.send_word(last_word);
		repeat (8) @(negedge clk);
		check_word("input_word", last_word, input_word);
	endtask

	// strobe held 6 clk so the filter sees it; no shifting meanwhile
	task automatic load();
		load_strobe_n <= 1'b0;
		repeat (6) @(negedge clk);
		load_strobe_n <= 1'b1;
		repeat (6) @(negedge clk);
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		load_strobe_n = 1'b1;
		clear_n = 1'b1;
		clear_level_select = 1'b0;
		cur = '{4{12'h000}};
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		check_codes();
		check_word("input_word", 16'h0000, input_word);
		// each channel code in turn; untouched channels must stay put
		for (int i = 0; i < 4; i++) begin
			send(i[1:0], DATA[i]);
			load();
			cur[i] = DATA[i];
			check_codes();
		end
		// zero-scale clear raised while a frame holds chip select low
		cur = '{4{`QDC_CLR_ZERO}};
		fork
			send(2'b11, DATA[3]); // same word again, so the held word stays known
			begin
				repeat (2) @(negedge clk);
				clear_n <= 1'b0;
				repeat (8) @(negedge clk);
				check_codes();
			end
		join
		check_word("input_word", last_word, input_word);
		clear_n <= 1'b1;
		repeat (20) @(negedge clk);
		check_codes();
		load(); // restores the word held before the clear
		cur[3] = DATA[3];
		check_codes();
		// midscale clear with a load strobe at the same moment
		clear_level_select <= 1'b1;
		repeat (5) @(negedge clk);
		clear_n <= 1'b0;
		load_strobe_n <= 1'b0;
		repeat (8) @(negedge clk);
		cur = '{4{`QDC_CLR_MID}};
		check_codes();
		load_strobe_n <= 1'b1;
		repeat (6) @(negedge clk);
		clear_n <= 1'b1;
		repeat (10) @(negedge clk);
		check_codes();
		// new word after the clear reaches only its channel
		send(2'b00, 12'h2d4);
		load();
		cur[0] = 12'h2d4;
		check_codes();
		print_verdict();
	end

	// watchdog: the sequence needs about 2.5 us
	initial begin
		#40000;
		fail_count++;
		print_verdict();
	end
endmodule // qdc_top_tb
